/* lockout_pkg.sv */
package lockout_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int DEBOUNCE_TIME_US = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_FREQ_MHZ;
  localparam int NUM_CHANNELS = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] BEAM_OFS = 5'h08;
  localparam logic [4:0] POLL_OFS = 5'h0C;
  localparam logic [4:0] IRQ_STATUS_OFS = 5'h10;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_RELEASE_BIT = 0;
  localparam int STATUS_LOCKOUT_BIT = 0;
  localparam int STATUS_SAFE_BIT = 1;
  localparam int STATUS_POLL_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_ENTER_BIT = 0;
  localparam int IRQ_RELEASE_BIT = 1;
  localparam int IRQ_POLL_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic CONTACT_IDLE = 1'b1;
  localparam logic BUTTON_IDLE = 1'b0;

  typedef enum logic [1:0] {ST_LOCKED, ST_ARMED, ST_RUN} run_state_type;

endpackage

/* debounce_filter.sv */
`timescale 1ns/1ps
module debounce_filter
  import lockout_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYCLES,
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Raw and filtered level
  input wire logic raw_i,
  output logic stable_o
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } filt_type;

  filt_type q;
  filt_type next_q;

  ////////////////////////////////////////////////////////////////////////////
  // Level accepted after CYCLES stable samples
  always_comb begin
    next_q = q;
    if (raw_i == q.level) begin
      next_q.cnt = '0;
    end else if (q.cnt == CW'(CYCLES - 1)) begin
      next_q.cnt = '0;
      next_q.level = raw_i;
    end else begin
      next_q.cnt = q.cnt + CW'(1);
    end
    if (!rst_b_i) begin
      next_q.cnt = '0;
      next_q.level = INIT;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= next_q;
  end

  assign stable_o = q.level;

endmodule

/* safety_restart_lockout.sv */
//
// Contract
// (RULE1) Any interrupted beam puts the controller into restart lockout, shown by a blinking alarm indicator.
// (RULE2) Lockout ends only after the restart contact opens then closes, or the reset button is pressed; the code also releases on a CTRL write.
// (RULE3) Release requests are ignored while any beam is interrupted, so the lockout holds.
// (RULE4) The safety output stays off during lockout.
// (RULE5) Beam channel indications keep tracking the sensors during lockout to allow alignment.
// (RULE6) Each receiver's lens contamination report appears on its own yellow indicator.
// (RULE7) A separate yellow pollution indicator is driven for every channel from that channel's report.
// (RULE8) The collective pollution output is the OR of all channel contamination reports.
// (RULE9) Open then close are two debounced ordered edges; a close with no open since lockout entry does not release.
// (RULE10) Pollution signals never affect the lockout state or the safety output.
//
`timescale 1ns/1ps
module safety_restart_lockout
  import lockout_pkg::*;
#(
  parameter int NUM_CH = NUM_CHANNELS,
  parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
  parameter int BLINK_HALF_CNT = BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // Receivers and contacts
  input wire logic [NUM_CH-1:0] beam_clear_i,
  input wire logic [NUM_CH-1:0] pollution_i,
  input wire logic restart_contact_i,
  input wire logic reset_button_i,
  // Relay and indicators
  output logic safety_o,
  output logic restart_lockout_o,
  output logic alarm_lockout_indicator_o,
  output logic [NUM_CH-1:0] chan_ok_o,
  output logic [NUM_CH-1:0] poll_led_o,
  output logic pollution_output_o
);

  localparam int BW = $clog2(BLINK_HALF_CNT + 1);

  typedef struct packed {
    run_state_type state;
    logic safe;
    logic [BW-1:0] blink_cnt;
    logic blink;
    logic [NUM_CH-1:0] chan_ok;
    logic [NUM_CH-1:0] poll_led;
    logic poll_out;
    logic contact_prev;
    logic button_prev;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } state_type;

  state_type q;
  state_type next_q;
  logic contact_db;
  logic button_db;
  logic all_clear;
  logic open_edge;
  logic close_edge;
  logic button_edge;
  logic sw_release;
  logic bus_req;
  logic bus_do;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Contact filters
  debounce_filter #(
    .CYCLES(DEBOUNCE_CNT),
    .INIT(CONTACT_IDLE)
  ) contact_filt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .raw_i(restart_contact_i),
    .stable_o(contact_db)
  );

  debounce_filter #(
    .CYCLES(DEBOUNCE_CNT),
    .INIT(BUTTON_IDLE)
  ) button_filt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .raw_i(reset_button_i),
    .stable_o(button_db)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  assign all_clear = &beam_clear_i;
  assign open_edge = q.contact_prev & ~contact_db; // [RULE9]
  assign close_edge = ~q.contact_prev & contact_db; // [RULE9]
  assign button_edge = ~q.button_prev & button_db;
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_do = bus_req & q.ack;
  assign sw_release = avs_write_i & q.ack & (avs_address_i == CTRL_OFS) & avs_byteenable_i[0]
                      & avs_writedata_i[CTRL_RELEASE_BIT];
  assign avs_waitrequest_o = bus_req & ~q.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    irq_set = '0;
    irq_clr = '0;
    next_q.contact_prev = contact_db;
    next_q.button_prev = button_db;
    // Lockout sequencing, pollution not consulted here [RULE10]
    unique case (q.state)
      ST_RUN: begin
        if (!all_clear) begin
          next_q.state = ST_LOCKED; // [RULE1]
        end
      end
      ST_LOCKED: begin
        if (!all_clear) begin
          next_q.state = ST_LOCKED; // [RULE3]
        end else if (button_edge || sw_release) begin
          next_q.state = ST_RUN; // [RULE2]
        end else if (open_edge) begin
          next_q.state = ST_ARMED; // [RULE9]
        end
      end
      ST_ARMED: begin
        if (!all_clear) begin
          next_q.state = ST_LOCKED; // [RULE3]
        end else if (close_edge || button_edge || sw_release) begin
          next_q.state = ST_RUN; // [RULE2]
        end
      end
      default: next_q.state = ST_LOCKED;
    endcase
    next_q.safe = (next_q.state == ST_RUN); // [RULE4]
    // Alarm blink while locked
    if (q.state != ST_RUN) begin
      if (q.blink_cnt == BW'(BLINK_HALF_CNT - 1)) begin
        next_q.blink_cnt = '0;
        next_q.blink = ~q.blink; // [RULE1]
      end else begin
        next_q.blink_cnt = q.blink_cnt + BW'(1);
      end
    end else begin
      next_q.blink_cnt = '0;
      next_q.blink = 1'b0;
    end
    // Channel indicators in every state
    next_q.chan_ok = beam_clear_i; // [RULE5]
    next_q.poll_led = pollution_i; // [RULE6] [RULE7]
    next_q.poll_out = |pollution_i; // [RULE8]
    // Events
    irq_set[IRQ_ENTER_BIT] = (q.state == ST_RUN) && (next_q.state != ST_RUN);
    irq_set[IRQ_RELEASE_BIT] = (q.state != ST_RUN) && (next_q.state == ST_RUN);
    irq_set[IRQ_POLL_BIT] = ~q.poll_out & next_q.poll_out;
    // Bus: one wait cycle, read data captured before accept
    next_q.ack = bus_req & ~q.ack;
    if (bus_req && !q.ack) begin
      unique case (avs_address_i)
        STATUS_OFS: begin
          next_q.rdata = '0;
          next_q.rdata[STATUS_LOCKOUT_BIT] = (q.state != ST_RUN);
          next_q.rdata[STATUS_SAFE_BIT] = q.safe;
          next_q.rdata[STATUS_POLL_BIT] = q.poll_out;
        end
        BEAM_OFS: next_q.rdata = 32'(q.chan_ok);
        POLL_OFS: next_q.rdata = 32'(q.poll_led);
        IRQ_STATUS_OFS: next_q.rdata = 32'(q.irq_status);
        IRQ_MASK_OFS: next_q.rdata = 32'(q.irq_mask);
        default: next_q.rdata = '0;
      endcase
    end
    if (bus_do && avs_read_i && avs_address_i == IRQ_STATUS_OFS) begin
      irq_clr = q.rdata[IRQ_W-1:0];
    end
    if (bus_do && avs_write_i && avs_address_i == IRQ_MASK_OFS && avs_byteenable_i[0]) begin
      next_q.irq_mask = avs_writedata_i[IRQ_W-1:0];
    end
    // Set wins over read-clear
    next_q.irq_status = (q.irq_status & ~irq_clr) | irq_set;
    if (!rst_b_i) begin
      next_q = '0;
      next_q.state = ST_LOCKED;
      next_q.contact_prev = CONTACT_IDLE;
      next_q.button_prev = BUTTON_IDLE;
      next_q.irq_mask = IRQ_MASK_RESET;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign safety_o = q.safe;
  assign restart_lockout_o = (q.state != ST_RUN);
  assign alarm_lockout_indicator_o = q.blink;
  assign chan_ok_o = q.chan_ok;
  assign poll_led_o = q.poll_led;
  assign pollution_output_o = q.poll_out;
  assign avs_readdata_o = q.rdata;
  assign irq_o = |(q.irq_status & q.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [BW:0] lock_cycles;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || q.state == ST_RUN) begin
      lock_cycles <= '0;
    end else if (lock_cycles != {1'b1, {BW{1'b0}}}) begin
      lock_cycles <= lock_cycles + (BW + 1)'(1);
    end
  end

  sequence locked_clear_s;
    (q.state == ST_LOCKED) && all_clear;
  endsequence

  sequence close_only_s;
    close_edge && !button_edge && !sw_release;
  endsequence

  sequence armed_break_s;
    (q.state == ST_ARMED) && !all_clear;
  endsequence

  sequence open_only_s;
    open_edge && !button_edge && !sw_release;
  endsequence

  sequence status_req_s;
    avs_read_i && avs_waitrequest_o && (avs_address_i == STATUS_OFS);
  endsequence

  sequence irq_take_s;
    avs_read_i && !avs_waitrequest_o && (avs_address_i == IRQ_STATUS_OFS);
  endsequence

  beam_break_lock_a: assert property (!all_clear |=> restart_lockout_o && !safety_o) // [RULE1]
    else $error("beam break did not lock");
  blink_starts_a: assert property (restart_lockout_o && lock_cycles == (BW + 1)'(BLINK_HALF_CNT - 1) // [RULE1]
    |-> !alarm_lockout_indicator_o ##1 alarm_lockout_indicator_o)
    else $error("alarm did not blink in lockout");
  blink_period_a: assert property ($changed(alarm_lockout_indicator_o) && restart_lockout_o // [RULE1]
    && lock_cycles > (BW + 1)'(BLINK_HALF_CNT) |-> q.blink_cnt == '0)
    else $error("blink period wrong");
  release_cause_a: assert property ($rose(safety_o) // [RULE2]
    |-> $past(button_edge || sw_release || (close_edge && q.state == ST_ARMED)))
    else $error("release without valid request");
  release_clear_a: assert property ($rose(safety_o) |-> $past(all_clear)) // [RULE3]
    else $error("release while beam interrupted");
  lock_output_off_a: assert property (restart_lockout_o |-> !safety_o) // [RULE4]
    else $error("safety output on in lockout");
  chan_track_a: assert property (1'b1 |=> chan_ok_o == $past(beam_clear_i)) // [RULE5]
    else $error("channel indication stale");
  poll_led_a: assert property (1'b1 |=> poll_led_o == $past(pollution_i)) // [RULE6] [RULE7]
    else $error("pollution indicator stale");
  poll_or_a: assert property (1'b1 |=> pollution_output_o == $past(|pollution_i)) // [RULE8]
    else $error("collective pollution wrong");
  close_no_open_a: assert property (locked_clear_s ##0 close_only_s |=> restart_lockout_o) // [RULE9]
    else $error("close without open released");
  poll_isolated_a: assert property (safety_o && all_clear |=> safety_o) // [RULE10]
    else $error("safety output dropped without beam break");
  bus_answer_a: assert property (bus_req && avs_waitrequest_o && $stable(avs_address_i)
    |=> !avs_waitrequest_o)
    else $error("bus answer late");
  armed_break_a: assert property (armed_break_s |=> q.state == ST_LOCKED) // [RULE3]
    else $error("armed state kept during beam break");
  open_arms_a: assert property (locked_clear_s ##0 open_only_s |=> q.state == ST_ARMED) // [RULE9]
    else $error("open edge did not arm release");
  button_release_a: assert property (restart_lockout_o && all_clear && button_edge |=> safety_o) // [RULE2]
    else $error("button press did not release");
  alarm_run_off_a: assert property (!restart_lockout_o |=> !alarm_lockout_indicator_o) // [RULE1]
    else $error("alarm lit while running");
  enter_event_a: assert property ($rose(restart_lockout_o) |-> q.irq_status[IRQ_ENTER_BIT])
    else $error("lockout entry event lost");
  release_event_a: assert property ($rose(safety_o) |-> q.irq_status[IRQ_RELEASE_BIT])
    else $error("release event lost");
  poll_event_a: assert property ($rose(pollution_output_o) |-> q.irq_status[IRQ_POLL_BIT])
    else $error("pollution event lost");
  status_read_a: assert property (status_req_s // [RULE4]
    |=> avs_readdata_o[STATUS_LOCKOUT_BIT] == $past(restart_lockout_o)
    && avs_readdata_o[STATUS_SAFE_BIT] == $past(safety_o))
    else $error("status read wrong");
  irq_clear_a: assert property (irq_take_s
    |=> (q.irq_status & $past(avs_readdata_o[IRQ_W-1:0]) & ~$past(irq_set)) == '0)
    else $error("event bits not cleared by read");

endmodule

/* barrier_rx_model.sv */
`timescale 1ns/1ps
// Receivers, restart contact and reset button
module barrier_rx_model #(
  parameter int NUM_CH = 3
) (
  // Clock
  input wire logic mclk_i,
  // Commands from the bench
  input wire logic [NUM_CH-1:0] beam_cmd_i,
  input wire logic [NUM_CH-1:0] dirt_cmd_i,
  input wire logic open_cmd_i,
  input wire logic press_cmd_i,
  // Lines to the controller
  output logic [NUM_CH-1:0] beam_clear_o = '1,
  output logic [NUM_CH-1:0] pollution_o = '0,
  output logic restart_contact_o = 1'b1,
  output logic reset_button_o = 1'b0
);
  // Lines change only at clock edges
  always @(posedge mclk_i) begin
    beam_clear_o <= beam_cmd_i;
    pollution_o <= dirt_cmd_i;
    restart_contact_o <= ~open_cmd_i;
    reset_button_o <= press_cmd_i;
  end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import lockout_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic wait_rq, irq, safe, lock, alarm, poll_out, contact, button;
  logic [2:0] beam_cmd = 3'h7;
  logic [2:0] dirt_cmd = 3'h0;
  logic [2:0] beam, dirt, chan_ok, poll_led;
  logic open_cmd = 1'b0;
  logic press_cmd = 1'b0;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  always #5 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  safety_restart_lockout #(.NUM_CH(3), .DEBOUNCE_CNT(4), .BLINK_HALF_CNT(8)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_rq),
    .irq_o(irq), .beam_clear_i(beam), .pollution_i(dirt), .restart_contact_i(contact),
    .reset_button_i(button), .safety_o(safe), .restart_lockout_o(lock),
    .alarm_lockout_indicator_o(alarm), .chan_ok_o(chan_ok), .poll_led_o(poll_led),
    .pollution_output_o(poll_out));

  barrier_rx_model #(.NUM_CH(3)) rx (
    .mclk_i(mclk_i), .beam_cmd_i(beam_cmd), .dirt_cmd_i(dirt_cmd), .open_cmd_i(open_cmd),
    .press_cmd_i(press_cmd), .beam_clear_o(beam), .pollution_o(dirt), .restart_contact_o(contact),
    .reset_button_o(button));

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, act);
    end
  endtask

  // Avalon cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge mclk_i);
    end while (wait_rq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task reg_chk(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0, got);
    chk(nm, exp, got);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = safe;
      1: pick = alarm;
      default: pick = lock;
    endcase
  endfunction

  task wait_pin(input string nm, input int s, input logic v, input int max);
    int n;
    n = 0;
    while (pick(s) !== v && n < max) begin
      @(negedge mclk_i);
      n++;
    end
    chk(nm, v, pick(s));
  endtask

  task idle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task press;
    @(posedge mclk_i);
    press_cmd <= 1'b1;
    repeat (10) @(posedge mclk_i);
    press_cmd <= 1'b0;
  endtask

  task open_close;
    @(posedge mclk_i);
    open_cmd <= 1'b1;
    repeat (10) @(posedge mclk_i);
    open_cmd <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    idle(1);
    chk("safety", 0, safe);
    reg_chk(STATUS_OFS, 32'h1, "status");
    reg_chk(IRQ_MASK_OFS, 32'h0, "mask");
    reg_chk(5'h18, 32'h0, "unmapped");
    idle(10);
    chk("reset locked", 1, lock);
    press();
    wait_pin("run by button", 0, 1'b1, 20);
    chk("alarm off", 0, alarm);
    reg_chk(IRQ_STATUS_OFS, 32'h2, "irq release");
    reg_chk(IRQ_STATUS_OFS, 32'h0, "irq cleared");
    bus(1'b1, IRQ_MASK_OFS, 32'h1, got);
    reg_chk(IRQ_MASK_OFS, 32'h1, "mask");
    beam_cmd <= 3'h5;
    wait_pin("safety off", 0, 1'b0, 4);
    chk("lockout", 1, lock);
    chk("chan ok", 3'h5, chan_ok);
    wait_pin("blink on", 1, 1'b1, 20);
    wait_pin("blink off", 1, 1'b0, 12);
    chk("irq", 1, irq);
    reg_chk(BEAM_OFS, 32'h5, "beam reg");
    press();
    bus(1'b1, CTRL_OFS, 32'h1, got);
    open_cmd <= 1'b1;
    idle(12);
    chk("held by beam", 1, lock);
    chk("relay held off", 0, safe);
    reg_chk(IRQ_STATUS_OFS, 32'h1, "irq enter");
    idle(1);
    chk("irq low", 0, irq);
    beam_cmd <= 3'h7;
    idle(12);
    chk("chan ok", 3'h7, chan_ok);
    chk("still locked", 1, lock);
    open_cmd <= 1'b0;
    idle(12);
    chk("close only", 1, lock);
    open_close();
    wait_pin("run by contact", 0, 1'b1, 20);
    dirt_cmd <= 3'h2;
    idle(3);
    chk("poll led", 3'h2, poll_led);
    chk("poll out", 1, poll_out);
    chk("relay on", 1, safe);
    reg_chk(POLL_OFS, 32'h2, "poll reg");
    reg_chk(STATUS_OFS, 32'h6, "status");
    reg_chk(IRQ_STATUS_OFS, 32'h6, "irq poll");
    beam_cmd <= 3'h6;
    dirt_cmd <= 3'h0;
    idle(3);
    beam_cmd <= 3'h7;
    idle(12);
    chk("poll out", 0, poll_out);
    chk("relock", 1, lock);
    bus(1'b1, CTRL_OFS, 32'h1, got);
    wait_pin("run by ctrl", 0, 1'b1, 20);
    give_verdict();
  end
endmodule
